// [verilog/hrms_sequencer.sv]
// Home, incremental and registration move sequencer with value store
`timescale 1ns/1ps
module hrms_sequencer #(
  parameter hrms_pkg::hrms_trig_src_t HOME_SRC_CFG = hrms_pkg::TRIG_EVENT_ONE,
  parameter hrms_pkg::hrms_trig_src_t REG_SRC_CFG = hrms_pkg::TRIG_EVENT_TWO,
  parameter int STORE_DEPTH = hrms_pkg::STORE_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  input wire hrms_pkg::hrms_cmd_t cmd_op,
  input wire logic [hrms_pkg::OP_W-1:0] cmd_operand,
  // Trigger and encoder inputs
  input wire logic event_in_one,
  input wire logic event_in_two,
  input wire logic marker_in,
  input wire logic enc_step,
  input wire logic enc_dir,
  // Motion status
  output logic busy,
  output logic motion_dir,
  output logic [hrms_pkg::VEL_W-1:0] velocity,
  output logic [hrms_pkg::POS_W-1:0] commanded_position,
  output logic [hrms_pkg::POS_W-1:0] measured_position,
  output logic [hrms_pkg::ERR_W-1:0] error_code,
  output logic error_strobe,
  output logic [1:0] home_source,
  output logic [1:0] registration_source,
  output logic [2:0] motion_start_trigger_level,
  // Retained value store
  input wire logic store_wr,
  input wire logic store_rd,
  input wire logic [hrms_pkg::ADDR_W-1:0] store_addr,
  input wire logic [hrms_pkg::DATA_W-1:0] store_wdata,
  output logic [hrms_pkg::DATA_W-1:0] store_rdata,
  output logic store_rvalid,
  output logic store_addr_err
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    hrms_pkg::hrms_state_t state;
    logic [hrms_pkg::DIV_W-1:0] div;
    logic dir;
    logic braking;
    logic use_max;
    logic [hrms_pkg::VEL_W-1:0] speed_set;
    logic [hrms_pkg::VEL_W-1:0] run_speed;
    logic [hrms_pkg::VEL_W-1:0] accel;
    logic [hrms_pkg::VEL_W-1:0] deceleration_rate;
    logic [hrms_pkg::VEL_W-1:0] max_accel;
    logic [hrms_pkg::REM_W-1:0] reg_limit;
    logic [hrms_pkg::REM_W-1:0] rem;
    logic [hrms_pkg::REM_W-1:0] reg_dist;
    logic [hrms_pkg::REM_W-1:0] travel;
    logic [hrms_pkg::POS_W-1:0] cmd_pos;
    logic [hrms_pkg::POS_W-1:0] meas_pos;
    logic [hrms_pkg::POS_W-1:0] trig_cmd;
    logic [hrms_pkg::POS_W-1:0] trig_meas;
    hrms_pkg::hrms_trig_src_t home_src;
    hrms_pkg::hrms_trig_src_t reg_src;
    logic [2:0] mst_level;
    logic [hrms_pkg::ERR_W-1:0] err_code;
    logic err_pulse;
    logic [2:0] ev_prev;
  } hrms_seq_st_t;

  hrms_seq_st_t s_reg;
  hrms_seq_st_t s_next;

  hrms_link_if lnk();

  hrms_profile u_profile (
    .clk_sys(clk_sys),
    .rst(rst),
    .lnk(lnk.prof)
  );

  hrms_store #(
    .DEPTH(STORE_DEPTH)
  ) u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .lnk(lnk.store)
  );

  function automatic logic src_level(hrms_pkg::hrms_trig_src_t src,
                                     logic [2:0] lv);
    case (src)
      hrms_pkg::TRIG_EVENT_ONE: src_level = lv[0];
      hrms_pkg::TRIG_EVENT_TWO: src_level = lv[1];
      hrms_pkg::TRIG_MARKER: src_level = lv[2];
      default: src_level = 1'b0;
    endcase
  endfunction : src_level

  function automatic logic is_event(hrms_pkg::hrms_trig_src_t src);
    is_event = (src == hrms_pkg::TRIG_EVENT_ONE) ||
      (src == hrms_pkg::TRIG_EVENT_TWO);
  endfunction : is_event

  // ****************************************
  // Next state
  // ****************************************
  logic tick;
  logic [2:0] ev_now;
  logic [2:0] ev_rise;
  logic neg_op;
  logic [hrms_pkg::OP_W-1:0] op_mag;
  logic [hrms_pkg::REM_W-1:0] step;
  logic [hrms_pkg::POS_W-1:0] step_pos;
  logic [63:0] vel_sq;
  logic [63:0] brake_room;
  logic [63:0] feas_room;
  logic home_hit;
  logic reg_hit;
  hrms_pkg::hrms_trig_src_t setup_src;

  always_comb begin
    s_next = s_reg;
    s_next.err_pulse = 1'b0;
    tick = (s_reg.div == hrms_pkg::DIV_LAST);
    s_next.div = tick ? '0 : s_reg.div + 1'b1;
    ev_now = {marker_in, event_in_two, event_in_one};
    ev_rise = ev_now & ~s_reg.ev_prev;
    s_next.ev_prev = ev_now;
    neg_op = cmd_operand[hrms_pkg::OP_W-1];
    op_mag = neg_op ? -cmd_operand : cmd_operand;
    home_hit = src_level(s_reg.home_src, ev_rise);
    reg_hit = src_level(s_reg.reg_src, ev_rise);
    vel_sq = 64'(lnk.vel) * 64'(lnk.vel);
    brake_room = (64'(s_reg.deceleration_rate) * 64'(s_reg.rem)) << 1;
    feas_room = ((64'(s_reg.deceleration_rate) * 64'(s_reg.reg_dist)) << 1) *
      hrms_pkg::FEAS_NUM;
    setup_src = hrms_pkg::TRIG_OFF;

    // Targeted moves never step past the remaining distance
    if ((s_reg.state == hrms_pkg::ST_INC_RUN) ||
        (s_reg.state == hrms_pkg::ST_REG_DIST)) begin
      step = (hrms_pkg::REM_W'(lnk.vel) > s_reg.rem) ?
        s_reg.rem : hrms_pkg::REM_W'(lnk.vel);
    end else begin
      step = hrms_pkg::REM_W'(lnk.vel);
    end
    step = tick ? step : '0;
    step_pos = step[hrms_pkg::POS_W-1:0];
    s_next.cmd_pos = s_reg.dir ? s_reg.cmd_pos - step_pos :
      s_reg.cmd_pos + step_pos;
    if (enc_step) begin
      s_next.meas_pos = enc_dir ? s_reg.meas_pos - 1'b1 :
        s_reg.meas_pos + 1'b1;
    end

    // Commands
    if (cmd_valid) begin
      case (cmd_op)
        hrms_pkg::set_speed:
          s_next.speed_set = cmd_operand[hrms_pkg::VEL_W-1:0];
        hrms_pkg::set_acceleration:
          s_next.accel = cmd_operand[hrms_pkg::VEL_W-1:0];
        hrms_pkg::set_deceleration_rate:
          s_next.deceleration_rate = cmd_operand[hrms_pkg::VEL_W-1:0];
        hrms_pkg::set_max_acceleration:
          s_next.max_accel = cmd_operand[hrms_pkg::VEL_W-1:0];
        hrms_pkg::set_registration_travel_limit:
          s_next.reg_limit = op_mag[hrms_pkg::REM_W-1:0];
        hrms_pkg::trigger_one_setup,
        hrms_pkg::trigger_two_setup,
        hrms_pkg::marker_trigger_setup: begin
          // Operand bit 0 picks the role, bit 1 enables the source
          if (cmd_op == hrms_pkg::trigger_one_setup) begin
            setup_src = hrms_pkg::TRIG_EVENT_ONE;
          end else if (cmd_op == hrms_pkg::trigger_two_setup) begin
            setup_src = hrms_pkg::TRIG_EVENT_TWO;
          end else begin
            setup_src = hrms_pkg::TRIG_MARKER;
          end
          if (!cmd_operand[1]) begin
            setup_src = hrms_pkg::TRIG_OFF;
          end
          if (!cmd_operand[0] && !busy) begin
            s_next.home_src = setup_src;
          end else if (cmd_operand[0] &&
                       (!busy || is_event(setup_src) ||
                        setup_src == hrms_pkg::TRIG_OFF)) begin
            s_next.reg_src = setup_src;
          end
        end
        hrms_pkg::set_motion_start_trigger_level: begin
          if (!busy) begin
            s_next.mst_level = (cmd_operand > 40'(hrms_pkg::MST_MAX)) ?
              hrms_pkg::MST_RESET : cmd_operand[2:0];
          end
        end
        hrms_pkg::home_cycle_cmd: begin
          if (!busy) begin
            s_next.dir = neg_op;
            s_next.run_speed = s_reg.speed_set;
            s_next.braking = 1'b0;
            s_next.use_max = 1'b0;
            if (is_event(s_reg.home_src) &&
                src_level(s_reg.home_src, ev_now)) begin
              s_next.cmd_pos = '0;
              s_next.meas_pos = '0;
            end else begin
              s_next.state = hrms_pkg::ST_HOME_RUN;
            end
          end
        end
        hrms_pkg::incremental_move_cmd,
        hrms_pkg::registration_move_cmd: begin
          if (!busy) begin
            s_next.dir = neg_op;
            s_next.run_speed = s_reg.speed_set;
            s_next.braking = 1'b0;
            s_next.use_max = 1'b0;
            s_next.rem = op_mag[hrms_pkg::REM_W-1:0];
            s_next.reg_dist = op_mag[hrms_pkg::REM_W-1:0];
            s_next.travel = '0;
            if (cmd_op == hrms_pkg::incremental_move_cmd) begin
              if (op_mag > hrms_pkg::MOVE_MAX) begin
                s_next.err_code = hrms_pkg::ERR_RANGE;
                s_next.err_pulse = 1'b1;
              end else if (op_mag != '0) begin
                s_next.state = hrms_pkg::ST_INC_RUN;
              end
            end else if (op_mag > hrms_pkg::REG_MAX) begin
              s_next.err_code = hrms_pkg::ERR_RANGE;
              s_next.err_pulse = 1'b1;
            end else if (is_event(s_reg.reg_src) &&
                         src_level(s_reg.reg_src, ev_now)) begin
              s_next.state = (op_mag != '0) ?
                hrms_pkg::ST_INC_RUN : hrms_pkg::ST_IDLE;
            end else begin
              s_next.state = hrms_pkg::ST_REG_SEEK;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Motion sequencing
    case (s_reg.state)
      hrms_pkg::ST_HOME_RUN: begin
        if (home_hit) begin
          s_next.trig_cmd = s_reg.cmd_pos;
          s_next.trig_meas = s_reg.meas_pos;
          s_next.braking = 1'b1;
          s_next.state = hrms_pkg::ST_HOME_STOP;
        end
      end
      hrms_pkg::ST_HOME_STOP: begin
        if (lnk.vel == hrms_pkg::ZERO_VEL) begin
          s_next.cmd_pos = s_reg.cmd_pos - s_reg.trig_cmd;
          s_next.meas_pos = s_next.meas_pos - s_reg.trig_meas;
          s_next.state = hrms_pkg::ST_IDLE;
        end
      end
      hrms_pkg::ST_INC_RUN,
      hrms_pkg::ST_REG_DIST: begin
        s_next.rem = s_reg.rem - step;
        if (vel_sq >= brake_room) begin
          s_next.braking = 1'b1;
        end
        if (s_next.rem == '0) begin
          s_next.state = hrms_pkg::ST_IDLE;
        end
      end
      hrms_pkg::ST_REG_SEEK: begin
        s_next.travel = s_reg.travel + step;
        if (reg_hit) begin
          s_next.trig_cmd = s_reg.cmd_pos;
          s_next.trig_meas = s_reg.meas_pos;
          if (vel_sq * hrms_pkg::FEAS_DEN <= feas_room) begin
            s_next.state = hrms_pkg::ST_REG_DIST;
            s_next.rem = s_reg.reg_dist;
          end else begin
            s_next.braking = 1'b1;
            s_next.use_max = 1'b1;
            s_next.err_code = hrms_pkg::ERR_NO_STOP;
            s_next.err_pulse = 1'b1;
            s_next.state = hrms_pkg::ST_HALT;
          end
        end else if ((s_reg.reg_limit != '0) &&
                     (s_next.travel >= s_reg.reg_limit)) begin
          s_next.braking = 1'b1;
          s_next.state = hrms_pkg::ST_HALT;
        end
      end
      hrms_pkg::ST_HALT: begin
        if (lnk.vel == hrms_pkg::ZERO_VEL) begin
          s_next.state = hrms_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.state <= hrms_pkg::ST_IDLE;
      s_reg.home_src <= HOME_SRC_CFG;
      s_reg.reg_src <= REG_SRC_CFG;
      s_reg.reg_limit <= hrms_pkg::REG_LIMIT_RESET;
      s_reg.mst_level <= hrms_pkg::MST_RESET;
      s_reg.err_code <= hrms_pkg::ERR_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Profile and store links
  // ****************************************
  always_comb begin
    lnk.tick = tick;
    lnk.go = (s_reg.state != hrms_pkg::ST_IDLE) && !s_reg.braking;
    lnk.brake = s_reg.braking;
    lnk.use_max = s_reg.use_max;
    // A zero-length finish forces rest at once
    lnk.halt = (s_reg.state == hrms_pkg::ST_IDLE);
    lnk.speed = s_reg.run_speed;
    lnk.accel = s_reg.accel;
    lnk.deceleration_rate = s_reg.deceleration_rate;
    lnk.max_accel = s_reg.max_accel;
    lnk.floor_vel = ((s_reg.state == hrms_pkg::ST_INC_RUN) ||
      (s_reg.state == hrms_pkg::ST_REG_DIST)) ?
      hrms_pkg::CREEP_VEL : hrms_pkg::ZERO_VEL;
    lnk.st_wr = store_wr;
    lnk.st_rd = store_rd;
    lnk.st_addr = store_addr;
    lnk.st_wdata = store_wdata;
  end

  assign busy = (s_reg.state != hrms_pkg::ST_IDLE);
  assign motion_dir = s_reg.dir;
  assign velocity = lnk.vel;
  assign commanded_position = s_reg.cmd_pos;
  assign measured_position = s_reg.meas_pos;
  assign error_code = s_reg.err_code;
  assign error_strobe = s_reg.err_pulse;
  assign home_source = s_reg.home_src;
  assign registration_source = s_reg.reg_src;
  assign motion_start_trigger_level = s_reg.mst_level;
  assign store_rdata = lnk.st_rdata;
  assign store_rvalid = lnk.st_rvalid;
  assign store_addr_err = lnk.st_err;

endmodule : hrms_sequencer

// [shared/hrms_pkg.sv]
// Constants, types and encodings shared by the move sequencer files
package hrms_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int POS_W = 32;
  localparam int OP_W = 40;
  localparam int VEL_W = 16;
  localparam int REM_W = 33;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 9;
  localparam int ERR_W = 8;
  localparam int DIV_W = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 250;
  localparam int CTRL_PERIOD_US = 1;
  localparam int CTRL_DIV = CTRL_PERIOD_US * CLK_FREQ_MHZ;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CTRL_DIV - 1);

  // ****************************************
  // Limits, error codes, reset values
  // ****************************************
  localparam logic [OP_W-1:0] MOVE_MAX = 40'h00_7FFF_FFFF;
  localparam logic [OP_W-1:0] REG_MAX = 40'h00_8000_1387;
  localparam logic [ERR_W-1:0] ERR_NONE = 8'h00;
  localparam logic [ERR_W-1:0] ERR_RANGE = 8'h15;
  localparam logic [ERR_W-1:0] ERR_NO_STOP = 8'h86;
  // Stopping margin of 0.96 as a ratio of integers
  localparam logic [63:0] FEAS_NUM = 64'h0000_0000_0000_0018;
  localparam logic [63:0] FEAS_DEN = 64'h0000_0000_0000_0019;
  localparam logic [REM_W-1:0] REG_LIMIT_RESET = 33'h0_0000_0000;
  localparam logic [2:0] MST_MAX = 3'h4;
  localparam logic [2:0] MST_RESET = 3'h0;
  localparam logic [VEL_W-1:0] CREEP_VEL = 16'h0001;
  localparam logic [VEL_W-1:0] ZERO_VEL = 16'h0000;
  localparam int STORE_DEPTH = 400;
  localparam logic [ADDR_W-1:0] STORE_FIRST = 9'h001;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    TRIG_OFF = 2'h0,
    TRIG_EVENT_ONE = 2'h1,
    TRIG_EVENT_TWO = 2'h2,
    TRIG_MARKER = 2'h3
  } hrms_trig_src_t;

  typedef enum logic [3:0] {
    set_speed = 4'h0,
    set_acceleration = 4'h1,
    set_deceleration_rate = 4'h2,
    set_max_acceleration = 4'h3,
    set_registration_travel_limit = 4'h4,
    home_cycle_cmd = 4'h5,
    incremental_move_cmd = 4'h6,
    registration_move_cmd = 4'h7,
    trigger_one_setup = 4'h8,
    trigger_two_setup = 4'h9,
    marker_trigger_setup = 4'hA,
    set_motion_start_trigger_level = 4'hB
  } hrms_cmd_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_HOME_RUN = 7'h02,
    ST_HOME_STOP = 7'h04,
    ST_INC_RUN = 7'h08,
    ST_REG_SEEK = 7'h10,
    ST_REG_DIST = 7'h20,
    ST_HALT = 7'h40
  } hrms_state_t;

endpackage : hrms_pkg

// [shared/hrms_link_if.sv]
// Internal links from the sequencer to its profile and store modules
`timescale 1ns/1ps
interface hrms_link_if;
  // Velocity profile
  logic tick;
  logic go;
  logic brake;
  logic use_max;
  logic halt;
  logic [hrms_pkg::VEL_W-1:0] speed;
  logic [hrms_pkg::VEL_W-1:0] accel;
  logic [hrms_pkg::VEL_W-1:0] deceleration_rate;
  logic [hrms_pkg::VEL_W-1:0] max_accel;
  logic [hrms_pkg::VEL_W-1:0] floor_vel;
  logic [hrms_pkg::VEL_W-1:0] vel;
  // Retained store
  logic st_wr;
  logic st_rd;
  logic [hrms_pkg::ADDR_W-1:0] st_addr;
  logic [hrms_pkg::DATA_W-1:0] st_wdata;
  logic [hrms_pkg::DATA_W-1:0] st_rdata;
  logic st_rvalid;
  logic st_err;

  modport seq (
    output tick, go, brake, use_max, halt, speed, accel, deceleration_rate, max_accel,
    output floor_vel, st_wr, st_rd, st_addr, st_wdata,
    input vel, st_rdata, st_rvalid, st_err
  );
  modport prof (
    input tick, go, brake, use_max, halt, speed, accel, deceleration_rate, max_accel,
    input floor_vel,
    output vel
  );
  modport store (
    input st_wr, st_rd, st_addr, st_wdata,
    output st_rdata, st_rvalid, st_err
  );
endinterface : hrms_link_if

// [verilog/hrms_profile.sv]
// Trapezoidal velocity generator stepped by the control tick
`timescale 1ns/1ps
module hrms_profile (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Sequencer link
  hrms_link_if.prof lnk
);

  typedef struct packed {
    logic [hrms_pkg::VEL_W-1:0] vel;
  } hrms_prof_st_t;

  hrms_prof_st_t s_reg;
  hrms_prof_st_t s_next;
  logic [hrms_pkg::VEL_W:0] up;
  logic [hrms_pkg::VEL_W-1:0] rate;

  always_comb begin
    s_next = s_reg;
    up = {1'b0, s_reg.vel} + {1'b0, lnk.accel};
    rate = lnk.use_max ? lnk.max_accel : lnk.deceleration_rate;
    if (lnk.halt) begin
      s_next.vel = hrms_pkg::ZERO_VEL;
    end else if (lnk.tick && lnk.brake) begin
      // Never drops below the floor so a short move still arrives
      if ({1'b0, s_reg.vel} > {1'b0, rate} + {1'b0, lnk.floor_vel}) begin
        s_next.vel = s_reg.vel - rate;
      end else begin
        s_next.vel = lnk.floor_vel;
      end
    end else if (lnk.tick && lnk.go) begin
      if (s_reg.vel > lnk.speed) begin
        s_next.vel = (s_reg.vel - lnk.speed > lnk.deceleration_rate) ?
          s_reg.vel - lnk.deceleration_rate : lnk.speed;
      end else if (up > {1'b0, lnk.speed}) begin
        s_next.vel = lnk.speed;
      end else begin
        s_next.vel = up[hrms_pkg::VEL_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.vel = s_reg.vel;

endmodule : hrms_profile

// [verilog/hrms_store.sv]
// Retained value store, one word per location, addressed from one
`timescale 1ns/1ps
module hrms_store #(
  parameter int DEPTH = hrms_pkg::STORE_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Sequencer link
  hrms_link_if.store lnk
);

  typedef struct packed {
    logic [DEPTH-1:0][hrms_pkg::DATA_W-1:0] mem;
    logic [hrms_pkg::DATA_W-1:0] rdata;
    logic rvalid;
    logic err;
  } hrms_store_st_t;

  hrms_store_st_t s_reg;
  hrms_store_st_t s_next;
  logic in_range;
  logic [hrms_pkg::ADDR_W-1:0] idx;

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.err = 1'b0;
    in_range = (lnk.st_addr >= hrms_pkg::STORE_FIRST) &&
      (lnk.st_addr <= hrms_pkg::ADDR_W'(DEPTH));
    idx = lnk.st_addr - hrms_pkg::STORE_FIRST;
    if (lnk.st_wr || lnk.st_rd) begin
      s_next.err = !in_range;
    end
    if (lnk.st_wr && in_range) begin
      s_next.mem[idx] = lnk.st_wdata;
    end else if (lnk.st_rd && !lnk.st_wr && in_range) begin
      // Refused or overridden reads return nothing
      s_next.rvalid = 1'b1;
      s_next.rdata = s_reg.mem[idx];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.st_rdata = s_reg.rdata;
  assign lnk.st_rvalid = s_reg.rvalid;
  assign lnk.st_err = s_reg.err;

endmodule : hrms_store

// [test/hrms_checker.sv]
// Port checker for the move sequencer
`timescale 1ns/1ps
module hrms_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire hrms_pkg::hrms_cmd_t cmd_op,
  input wire logic [hrms_pkg::OP_W-1:0] cmd_operand,
  input wire logic event_in_one,
  input wire logic busy,
  input wire logic motion_dir,
  input wire logic [hrms_pkg::POS_W-1:0] commanded_position,
  input wire logic [hrms_pkg::POS_W-1:0] measured_position,
  input wire logic [hrms_pkg::ERR_W-1:0] error_code,
  input wire logic error_strobe,
  input wire logic [1:0] home_source,
  input wire logic [2:0] motion_start_trigger_level,
  input wire logic store_wr,
  input wire logic store_rd,
  input wire logic [hrms_pkg::ADDR_W-1:0] store_addr,
  input wire logic store_rvalid,
  input wire logic store_addr_err
);
  logic [hrms_pkg::OP_W-1:0] mag;
  logic go;
  logic bad_addr;
  assign mag = cmd_operand[39] ? -cmd_operand : cmd_operand;
  assign go = cmd_valid && !busy;
  assign bad_addr = store_addr == 9'h000 || store_addr > 9'h190;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  inc_range_a: assert property (go && cmd_op == hrms_pkg::incremental_move_cmd
    && mag > hrms_pkg::MOVE_MAX |=> error_strobe && !busy
    && error_code == hrms_pkg::ERR_RANGE) else $error("inc range");
  reg_range_a: assert property (go && cmd_op == hrms_pkg::registration_move_cmd
    && mag > hrms_pkg::REG_MAX |=> error_strobe && !busy
    && error_code == hrms_pkg::ERR_RANGE) else $error("reg range");
  inc_start_a: assert property (go && cmd_op == hrms_pkg::incremental_move_cmd
    && mag != 0 && mag <= hrms_pkg::MOVE_MAX
    && motion_start_trigger_level == 3'h0 |=> busy
    && motion_dir == $past(cmd_operand[39]))
    else $error("inc start");
  home_zero_a: assert property (go && cmd_op == hrms_pkg::home_cycle_cmd
    && home_source == 2'h1 && event_in_one |=> !busy
    && commanded_position == 0 && measured_position == 0) else $error("home zero");
  home_dir_a: assert property (go && cmd_op == hrms_pkg::home_cycle_cmd
    && home_source == 2'h1 && !event_in_one && cmd_operand != 0
    && motion_start_trigger_level == 3'h0 |=> busy
    && motion_dir == $past(cmd_operand[39]))
    else $error("home dir");
  level_hold_a: assert property (busy && cmd_valid
    && cmd_op == hrms_pkg::set_motion_start_trigger_level |=> $stable(motion_start_trigger_level))
    else $error("level changed");
  store_ok_a: assert property ((store_rd && !store_wr && !bad_addr)
    |=> store_rvalid && !store_addr_err) else $error("store read");
  store_bad_a: assert property ((store_rd || store_wr) && bad_addr
    |=> store_addr_err && !store_rvalid) else $error("store addr");
  cover property (go && cmd_op == hrms_pkg::incremental_move_cmd);
  cover property (go && cmd_op == hrms_pkg::home_cycle_cmd);
  cover property (store_rvalid);
endmodule : hrms_checker
bind hrms_sequencer hrms_checker chk_u (.clk_sys, .rst, .cmd_valid, .cmd_op,
  .cmd_operand, .event_in_one, .busy, .motion_dir, .commanded_position,
  .measured_position, .error_code, .error_strobe, .home_source,
  .motion_start_trigger_level, .store_wr, .store_rd, .store_addr,
  .store_rvalid, .store_addr_err);

// [test/hrms_motor.sv]
// Motor and encoder model following the commanded position
`timescale 1ns/1ps
module hrms_motor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [hrms_pkg::POS_W-1:0] commanded_position,
  output logic enc_step,
  output logic enc_dir
);
  logic [31:0] shaft;
  // Step every other cycle, like a shaft with finite slew
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shaft <= 32'h0000_0000;
      enc_step <= 1'b0;
      enc_dir <= 1'b0;
    end else if (!enc_step && shaft != commanded_position) begin
      enc_step <= 1'b1;
      enc_dir <= $signed(commanded_position - shaft) < 0;
      shaft <= ($signed(commanded_position - shaft) < 0) ? shaft - 1 : shaft + 1;
    end else begin
      enc_step <= 1'b0;
    end
  end
endmodule : hrms_motor

// [test/test_home_registration_move_sequencer.sv]
// Self-checking bench for the move sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_home_registration_move_sequencer;
  logic clk_sys = 0, rst = 1, cmd_valid = 0, ev1 = 0, ev2 = 0;
  logic st_wr = 0, st_rd = 0, enc_step, enc_dir, busy, mdir, ser, srv, sae;
  hrms_pkg::hrms_cmd_t op = hrms_pkg::set_speed;
  logic [39:0] opd = 0;
  logic [8:0] sa = 0;
  logic [31:0] sd = 0, cpos, mpos, srd;
  logic [7:0] ecode;
  logic [15:0] vel;
  logic [1:0] hsrc, rsrc;
  logic [2:0] lvl;
  int fails = 0, compares = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  hrms_sequencer dut_u (.clk_sys, .rst, .cmd_valid, .cmd_op(op),
    .cmd_operand(opd), .event_in_one(ev1), .event_in_two(ev2),
    .marker_in(1'b0), .enc_step, .enc_dir, .busy, .motion_dir(mdir),
    .velocity(vel), .commanded_position(cpos), .measured_position(mpos),
    .error_code(ecode), .error_strobe(ser), .home_source(hsrc),
    .registration_source(rsrc), .motion_start_trigger_level(lvl),
    .store_wr(st_wr), .store_rd(st_rd), .store_addr(sa),
    .store_wdata(sd), .store_rdata(srd), .store_rvalid(srv),
    .store_addr_err(sae));
  hrms_motor motor_u (.clk_sys, .rst, .commanded_position(cpos),
    .enc_step, .enc_dir);
  task give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the longest move
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin fails++; give_verdict; end
  end
  task cmd(input hrms_pkg::hrms_cmd_t o, input logic [39:0] v);
    @(posedge clk_sys); cmd_valid <= 1; op <= o; opd <= v;
    @(posedge clk_sys); cmd_valid <= 0; #1;
  endtask : cmd
  task idle;
    for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys); #1;
    `CHK(busy, 1'b0)
  endtask : idle
  task st(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys); st_wr <= w; st_rd <= !w; sa <= a; sd <= d;
    @(posedge clk_sys); st_wr <= 0; st_rd <= 0; #1;
  endtask : st
  task t_inc;
    cmd(hrms_pkg::incremental_move_cmd, 40'h00_0000_0008);
    `CHK({busy, mdir}, 2'b10)
    cmd(hrms_pkg::set_motion_start_trigger_level, 40'h00_0000_0003);
    `CHK(lvl, 3'h0)
    idle;
    `CHK({cpos, mpos}, {32'h0000_0008, 32'h0000_0008})
    cmd(hrms_pkg::incremental_move_cmd, 40'hFF_FFFF_FFF8);
    `CHK(mdir, 1'b1)
    idle;
    `CHK(cpos, 32'h0000_0000)
  endtask : t_inc
  task t_range;
    cmd(hrms_pkg::incremental_move_cmd, 40'h00_8000_0000);
    `CHK({ser, busy, ecode}, {2'b10, 8'h15})
    cmd(hrms_pkg::registration_move_cmd, 40'hFF_7FFF_EC78);
    `CHK({ser, busy, ecode}, {2'b10, 8'h15})
  endtask : t_range
  task t_home;
    cmd(hrms_pkg::home_cycle_cmd, 40'hFF_FFFF_FFFF);
    `CHK({busy, mdir}, 2'b11)
    repeat (1500) @(posedge clk_sys);
    ev1 <= 1;
    idle;
    cmd(hrms_pkg::home_cycle_cmd, 40'h00_0000_0005);
    `CHK({busy, cpos, mpos}, 65'h0)
    @(posedge clk_sys);
    ev1 <= 0;
  endtask : t_home
  task t_reg;
    logic [31:0] p;
    @(posedge clk_sys);
    ev2 <= 1;
    cmd(hrms_pkg::registration_move_cmd, 40'h00_0000_0006);
    `CHK(busy, 1'b1)
    idle;
    `CHK(cpos, 32'h0000_0006)
    @(posedge clk_sys);
    ev2 <= 0;
    // Start with the trigger off, enable it while seeking
    cmd(hrms_pkg::trigger_two_setup, 40'h00_0000_0001);
    `CHK(rsrc, 2'h0)
    cmd(hrms_pkg::registration_move_cmd, 40'h00_0000_0014);
    cmd(hrms_pkg::trigger_two_setup, 40'h00_0000_0003);
    `CHK(rsrc, 2'h2)
    repeat (1500) @(posedge clk_sys);
    ev2 <= 1;
    #1;
    `CHK(vel, 16'h0004)
    @(posedge clk_sys);
    #1;
    p = cpos;
    idle;
    `CHK(cpos, p + 32'h0000_0014)
    @(posedge clk_sys);
    ev2 <= 0;
    // Too short to stop at speed 4
    cmd(hrms_pkg::registration_move_cmd, 40'h00_0000_0001);
    repeat (1500) @(posedge clk_sys);
    ev2 <= 1;
    @(posedge clk_sys);
    #1;
    `CHK({ser, ecode}, {1'b1, 8'h86})
    idle;
    @(posedge clk_sys);
    ev2 <= 0;
    cmd(hrms_pkg::set_registration_travel_limit, 40'h00_0000_0064);
    p = cpos;
    cmd(hrms_pkg::registration_move_cmd, 40'h00_0000_0006);
    idle;
    `CHK({ser, ecode, cpos - p >= 32'h0000_0064}, {1'b0, 8'h86, 1'b1})
  endtask : t_reg
  task t_store;
    st(1, 9'h190, 32'hA5C3_0F01);
    st(0, 9'h190, 32'h0);
    `CHK({srv, sae, srd}, {2'b10, 32'hA5C3_0F01})
    st(0, 9'h000, 32'h0);
    `CHK({srv, sae}, 2'b01)
  endtask : t_store
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    #1;
    `CHK({busy, cpos, mpos, ecode, lvl}, 76'h0)
    `CHK({hsrc, rsrc}, 4'h6)
    cmd(hrms_pkg::set_speed, 40'h00_0000_0004);
    cmd(hrms_pkg::set_acceleration, 40'h00_0000_0002);
    cmd(hrms_pkg::set_deceleration_rate, 40'h00_0000_0002);
    cmd(hrms_pkg::set_max_acceleration, 40'h00_0000_0008);
    t_inc;
    t_range;
    t_home;
    t_reg;
    t_store;
    give_verdict;
  end
endmodule : test_home_registration_move_sequencer
